// File: src/svof_map.svh
// Register map, reset values and timing counts of the video output block
`ifndef SVOF_MAP_SVH
`define SVOF_MAP_SVH
`define SVOF_ADDR_CTRL  8'h00
`define SVOF_ADDR_STAT  8'h04
`define SVOF_ADDR_COLS  8'h08
`define SVOF_ADDR_ROWS  8'h0c
`define SVOF_ADDR_HBLK  8'h10
`define SVOF_ADDR_VBLK  8'h14
`define SVOF_CTRL_RST   4'h3
`define SVOF_COLS_RST   16'h02f0
`define SVOF_ROWS_RST   16'h01e0
`define SVOF_HBLK_RST   16'h005e
`define SVOF_VBLK_RST   16'h002d
`define SVOF_FV_LEAD    16'h008f
`define SVOF_FV_TRAIL   16'h0017
`define SVOF_WORD_BITS  4'hc
`define SVOF_SYNC_WORD  12'hfc0
`define SVOF_RESP_OKAY  2'h0
`define SVOF_RESP_ERR   2'h2
`endif

// File: src/svof_pkg.sv
// Types shared by the video output block
package svof_pkg;
  typedef struct packed {
    logic       fv;
    logic       lv;
    logic [9:0] data;
  } svof_word_t;
  typedef struct packed {
    logic force_sync;
    logic soft_reset;
    logic ser_pwrdn;
    logic drv_dis;
  } svof_ctrl_t;
  typedef enum logic [2:0] {
    SVOF_IDLE  = 3'h0,
    SVOF_FRONT = 3'h1,
    SVOF_LINE  = 3'h3,
    SVOF_HBLK  = 3'h2,
    SVOF_BACK  = 3'h6,
    SVOF_VBLK  = 3'h7
  } svof_state_t;
endpackage : svof_pkg

// File: src/svof_top.sv
// Video output framing, serial link and AXI4-Lite control of the sensor
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "svof_map.svh"

module svof_top
  import svof_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        shift_clk,
  input  wire logic [9:0]  pixel_in,
  output logic             pixel_rate_clock,
  output logic [9:0]       pix_data,
  output logic             line_valid,
  output logic             frame_valid,
  output logic             serial_video_pos,
  output logic             serial_video_neg,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  function automatic logic hit(input logic [15:0] c, input logic [15:0] lim);
    hit = (lim <= 16'h0001) ? 1'b1 : (c == lim - 16'h0001);
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction : merge

  svof_ctrl_t  ctrl_reg;
  logic [15:0] cols_reg, rows_reg, hblk_reg, vblk_reg;
  svof_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next, row_reg, row_next;
  svof_word_t  out_reg, hold_reg;
  logic        req_reg;
  logic [2:0]  ack_sync_reg;
  logic        ack_q_reg;
  logic        ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic        aw_full_reg, w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit;

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_full_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_full_reg ? w_strb_reg : s_axi_wstrb;
  assign wr_fire = !s_axi_bvalid
                   && (aw_full_reg || s_axi_awvalid)
                   && (w_full_reg || s_axi_wvalid);
  assign wr_hit  = (wr_addr == `SVOF_ADDR_CTRL) || (wr_addr == `SVOF_ADDR_COLS)
                   || (wr_addr == `SVOF_ADDR_ROWS)
                   || (wr_addr == `SVOF_ADDR_HBLK)
                   || (wr_addr == `SVOF_ADDR_VBLK);

  // Address and data may arrive in either order; each is parked until both
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SVOF_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SVOF_RESP_OKAY : `SVOF_RESP_ERR;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_full_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_full_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      ctrl_reg <= `SVOF_CTRL_RST;
      cols_reg <= `SVOF_COLS_RST;
      rows_reg <= `SVOF_ROWS_RST;
      hblk_reg <= `SVOF_HBLK_RST;
      vblk_reg <= `SVOF_VBLK_RST;
    end
    else if (wr_fire)
      case (wr_addr)
        `SVOF_ADDR_CTRL: ctrl_reg <= 4'(merge({28'h0, ctrl_reg}, wr_data,
                                              wr_strb));
        `SVOF_ADDR_COLS: cols_reg <= 16'(merge({16'h0, cols_reg}, wr_data,
                                               wr_strb));
        `SVOF_ADDR_ROWS: rows_reg <= 16'(merge({16'h0, rows_reg}, wr_data,
                                               wr_strb));
        `SVOF_ADDR_HBLK: hblk_reg <= 16'(merge({16'h0, hblk_reg}, wr_data,
                                               wr_strb));
        `SVOF_ADDR_VBLK: vblk_reg <= 16'(merge({16'h0, vblk_reg}, wr_data,
                                               wr_strb));
        default: ;
      endcase

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `SVOF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SVOF_RESP_OKAY;
      case (s_axi_araddr)
        `SVOF_ADDR_CTRL: s_axi_rdata <= {28'h0, ctrl_reg};
        `SVOF_ADDR_STAT: s_axi_rdata <= {26'h0, req_reg != ack_q_reg,
                                         out_reg.fv, out_reg.lv, state_reg};
        `SVOF_ADDR_COLS: s_axi_rdata <= {16'h0, cols_reg};
        `SVOF_ADDR_ROWS: s_axi_rdata <= {16'h0, rows_reg};
        `SVOF_ADDR_HBLK: s_axi_rdata <= {16'h0, hblk_reg};
        `SVOF_ADDR_VBLK: s_axi_rdata <= {16'h0, vblk_reg};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `SVOF_RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer, one pixel per master clock

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 16'h0001;
    row_next   = row_reg;
    case (state_reg)
      SVOF_IDLE:
      begin
        state_next = SVOF_FRONT;
        cnt_next   = 16'h0;
        row_next   = 16'h0;
      end
      SVOF_FRONT:
        if (hit(cnt_reg, `SVOF_FV_LEAD))
        begin
          state_next = SVOF_LINE;
          cnt_next   = 16'h0;
        end
      SVOF_LINE:
        if (hit(cnt_reg, cols_reg))
        begin
          cnt_next = 16'h0;
          if (hit(row_reg, rows_reg))
          begin
            state_next = SVOF_BACK;
            row_next   = 16'h0;
          end
          else
          begin
            state_next = SVOF_HBLK;
            row_next   = row_reg + 16'h0001;
          end
        end
      SVOF_HBLK:
        if (hit(cnt_reg, hblk_reg))
        begin
          state_next = SVOF_LINE;
          cnt_next   = 16'h0;
        end
      SVOF_BACK:
        if (hit(cnt_reg, `SVOF_FV_TRAIL))
        begin
          state_next = SVOF_VBLK;
          cnt_next   = 16'h0;
        end
      SVOF_VBLK:
        if (hit(cnt_reg, vblk_reg))
        begin
          state_next = SVOF_FRONT;
          cnt_next   = 16'h0;
        end
      default:
      begin
        state_next = SVOF_IDLE;
        cnt_next   = 16'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      state_reg <= SVOF_IDLE;
      cnt_reg   <= 16'h0;
      row_reg   <= 16'h0;
    end
    else if (ctrl_reg.soft_reset)
    begin
      state_reg <= SVOF_IDLE;
      cnt_reg   <= 16'h0;
      row_reg   <= 16'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      row_reg   <= row_next;
    end

  // Flags and data leave one register so they share the same edge
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      out_reg <= '0;
    else if (ctrl_reg.soft_reset)
      out_reg <= '0;
    else
    begin
      out_reg.fv   <= (state_next != SVOF_IDLE)
                      && (state_next != SVOF_VBLK);
      out_reg.lv   <= (state_next == SVOF_LINE);
      out_reg.data <= (state_next == SVOF_LINE) ? pixel_in : 10'h000;
    end

  assign pix_data    = out_reg.data;
  assign line_valid  = out_reg.lv;
  assign frame_valid = out_reg.fv;
  // Clock buffer delay supplies the lag; falling edge meets data changes
  assign pixel_rate_clock = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Word handoff to the shift domain, toggle request and acknowledge

  logic cap;
  assign cap = (ack_q_reg == req_reg);

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      hold_reg <= '0;
      req_reg  <= 1'b0;
    end
    else if (cap)
    begin
      hold_reg <= ctrl_reg.force_sync ? `SVOF_SYNC_WORD : out_reg;
      req_reg  <= ~req_reg;
    end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      ack_sync_reg <= 3'h0;
      ack_q_reg    <= 1'b0;
    end
    else
    begin
      ack_sync_reg <= {ack_sync_reg[1:0], ack_reg};
      if (ack_sync_reg[2] == ack_sync_reg[1])
        ack_q_reg <= ack_sync_reg[2];
    end

  ////////////////////////////////////////////////////////////////////////////
  // Shift domain; words are dropped while the link is slower than pixels

  logic [2:0]  req_sync_reg;
  logic        req_q_reg;
  logic [2:0]  ctl_s1_reg, ctl_s2_reg, ctl_s3_reg, ctl_q_reg;
  logic [11:0] sh_reg;
  logic [3:0]  bit_cnt_reg;
  logic        ser_reg, link_on;

  assign link_on = (ctl_q_reg == 3'h0);

  always_ff @(posedge shift_clk or posedge rst)
    if (rst)
    begin
      req_sync_reg <= 3'h0;
      req_q_reg    <= 1'b0;
      ctl_s1_reg   <= 3'h3;
      ctl_s2_reg   <= 3'h3;
      ctl_s3_reg   <= 3'h3;
      ctl_q_reg    <= 3'h3;
    end
    else
    begin
      req_sync_reg <= {req_sync_reg[1:0], req_reg};
      if (req_sync_reg[2] == req_sync_reg[1])
        req_q_reg <= req_sync_reg[2];
      ctl_s1_reg <= {ctrl_reg.soft_reset, ctrl_reg.ser_pwrdn, ctrl_reg.drv_dis};
      ctl_s2_reg <= ctl_s1_reg;
      ctl_s3_reg <= ctl_s2_reg;
      if (ctl_s2_reg == ctl_s3_reg)
        ctl_q_reg <= ctl_s3_reg;
    end

  always_ff @(posedge shift_clk or posedge rst)
    if (rst)
    begin
      sh_reg      <= 12'h000;
      bit_cnt_reg <= 4'h0;
      ser_reg     <= 1'b0;
      ack_reg     <= 1'b0;
    end
    else if (!link_on)
    begin
      sh_reg      <= 12'h000;
      bit_cnt_reg <= 4'h0;
      ser_reg     <= 1'b0;
    end
    else if (bit_cnt_reg != 4'h0)
    begin
      ser_reg     <= sh_reg[0];
      sh_reg      <= sh_reg >> 1;
      bit_cnt_reg <= bit_cnt_reg - 4'h1;
    end
    else if (req_q_reg != ack_reg)
    begin
      ser_reg     <= hold_reg[0];
      sh_reg      <= hold_reg >> 1;
      bit_cnt_reg <= `SVOF_WORD_BITS - 4'h1;
      ack_reg     <= ~ack_reg;
    end
    else
      ser_reg <= 1'b0;

  assign serial_video_pos = ser_reg;
  assign serial_video_neg = ~ser_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [15:0] since_fv_reg;
  logic        lv_seen_reg;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      since_fv_reg <= 16'h0;
      lv_seen_reg  <= 1'b0;
    end
    else
    begin
      since_fv_reg <= out_reg.fv ? since_fv_reg + 16'h0001 : 16'h0;
      lv_seen_reg  <= out_reg.fv && (lv_seen_reg || out_reg.lv);
    end

  property p_flags_nest;
    @(posedge ref_clk) disable iff (rst) out_reg.lv |-> out_reg.fv;
  endproperty
  a_flags_nest: assert property (p_flags_nest)
    else $error("row flag high outside image flag");

  property p_lv_first_pix;
    @(posedge ref_clk) disable iff (rst)
      ($rose(out_reg.lv) && !$past(ctrl_reg.soft_reset))
        |-> out_reg.data == $past(pixel_in);
  endproperty
  a_lv_first_pix: assert property (p_lv_first_pix)
    else $error("first pixel not presented with row flag");

  property p_lv_end;
    @(posedge ref_clk) disable iff (rst)
      $fell(out_reg.lv) |-> out_reg.data == 10'h000;
  endproperty
  a_lv_end: assert property (p_lv_end)
    else $error("pixel data still driven after row end");

  property p_fv_lead;
    @(posedge ref_clk) disable iff (rst)
      ($rose(out_reg.lv) && !lv_seen_reg) |-> since_fv_reg == 16'd143;
  endproperty
  a_fv_lead: assert property (p_fv_lead)
    else $error("image flag lead is not 143 clocks");

  property p_fv_trail;
    @(posedge ref_clk) disable iff (rst || ctrl_reg.soft_reset)
      ($fell(out_reg.fv) && !$past(ctrl_reg.soft_reset))
        |-> $past(out_reg.lv, 24) && !$past(out_reg.lv, 23);
  endproperty
  a_fv_trail: assert property (p_fv_trail)
    else $error("image flag trail is not 23 clocks");

  property p_word_len;
    @(posedge shift_clk) disable iff (rst)
      (link_on && bit_cnt_reg == 4'h0 && req_q_reg != ack_reg)
        |=> bit_cnt_reg == `SVOF_WORD_BITS - 4'h1;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("serial word not twelve shift clocks");

  property p_word_flags;
    @(posedge ref_clk) disable iff (rst)
      (cap && !ctrl_reg.force_sync) |=> hold_reg == $past(out_reg);
  endproperty
  a_word_flags: assert property (p_word_flags)
    else $error("serial word lost flags or data");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (rst)
      ctrl_reg.soft_reset |=> state_reg == SVOF_IDLE && !out_reg.fv;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not reinitialise framing");

  property p_sync;
    @(posedge ref_clk) disable iff (rst)
      (cap && ctrl_reg.force_sync) |=> hold_reg == `SVOF_SYNC_WORD;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync word not sent while forced");

  property p_idle;
    @(posedge shift_clk) disable iff (rst)
      !link_on |=> !serial_video_pos && serial_video_neg;
  endproperty
  a_idle: assert property (p_idle)
    else $error("serial output active while link is off");

  c_frame: cover property (@(posedge ref_clk) disable iff (rst)
    $fell(out_reg.fv));
  c_sync: cover property (@(posedge ref_clk) disable iff (rst)
    cap && ctrl_reg.force_sync);
  c_word: cover property (@(posedge shift_clk) disable iff (rst)
    link_on && bit_cnt_reg == 4'h0 && req_q_reg != ack_reg);

endmodule : svof_top
`default_nettype wire

// File: test/svof_deser_model.sv
// Deserializer model at the far end of the serial video link
`timescale 1ns/1ns
`default_nettype none
`include "svof_map.svh"

module svof_deser_model
(
  input  wire logic        shift_clk,
  input  wire logic        rst,
  input  wire logic        ser_pos,
  input  wire logic        ser_neg,
  input  wire logic [11:0] match_word,
  output logic [15:0]      sync_cnt,
  output logic [15:0]      match_cnt,
  output logic [15:0]      pol_err
);
  logic [11:0] win_next;
  logic [11:0] win_reg;

  // Word arrives data bit 0 first, image flag last
  assign win_next = {ser_pos, win_reg[11:1]};

  // Bits taken mid-cell, clear of the launching edge; the receiver is
  // clocked from the link clock, near the master rate
  always_ff @(negedge shift_clk or posedge rst)
  begin
    if (rst)
    begin
      win_reg   <= 12'h000;
      sync_cnt  <= 16'h0000;
      match_cnt <= 16'h0000;
      pol_err   <= 16'h0000;
    end
    else
    begin
      win_reg <= win_next;
      if (ser_pos == ser_neg)
        pol_err <= pol_err + 16'h0001;
      if (win_next == `SVOF_SYNC_WORD)
        sync_cnt <= sync_cnt + 16'h0001;
      if (win_next == match_word)
        match_cnt <= match_cnt + 16'h0001;
    end
  end
endmodule : svof_deser_model
`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the video output block
`timescale 1ns/1ns
`default_nettype none
`include "svof_map.svh"

module tb;
  logic        ref_clk, rst, shift_clk, pix_step;
  logic [9:0]  pixel_in, pix_data;
  logic        pixel_rate_clock, line_valid, frame_valid;
  logic        ser_pos, ser_neg;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] sync_cnt, match_cnt, pol_err;
  int          err_count, n_checks, cyc, fv_age;

  svof_top u_svof_top (.ref_clk(ref_clk), .rst(rst), .shift_clk(shift_clk),
    .pixel_in(pixel_in), .pixel_rate_clock(pixel_rate_clock),
    .pix_data(pix_data), .line_valid(line_valid),
    .frame_valid(frame_valid), .serial_video_pos(ser_pos),
    .serial_video_neg(ser_neg), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

  svof_deser_model u_svof_deser_model (.shift_clk(shift_clk), .rst(rst),
    .ser_pos(ser_pos), .ser_neg(ser_neg), .match_word(12'heb5),
    .sync_cnt(sync_cnt), .match_cnt(match_cnt), .pol_err(pol_err));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Link clock, 125 ns, phase unrelated to the master clock
  initial
  begin
    shift_clk = 1'b0;
    #17;
    forever
    begin
      #63 shift_clk = 1'b1;
      #62 shift_clk = 1'b0;
    end
  end

  // Counting pixels make a skipped or late sample visible
  always @(posedge ref_clk)
    pixel_in <= pix_step ? pixel_in + 10'h001 : 10'h2b5;

  always @(negedge ref_clk)
    fv_age <= frame_valid ? fv_age + 1 : 0;

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      err_count++;
      stop_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        err_count++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask : check

  task automatic stop_test;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask : stop_test

  // Ready is judged on the falling edge, so it equals what the next
  // rising edge samples
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_hs, w_hs, done;
    logic [1:0] rsp;
    begin
      done = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!done)
      begin
        @(negedge ref_clk);
        aw_hs = s_axi_awvalid & s_axi_awready;
        w_hs  = s_axi_wvalid & s_axi_wready;
        done  = s_axi_bvalid;
        rsp   = s_axi_bresp;
        @(posedge ref_clk);
        if (aw_hs)
          s_axi_awvalid <= 1'b0;
        if (w_hs)
          s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      check("bresp", {30'h0, rsp}, {30'h0, er});
      @(posedge ref_clk);
    end
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    logic ar_hs, done;
    logic [31:0] d;
    logic [1:0] r;
    begin
      done = 1'b0;
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!done)
      begin
        @(negedge ref_clk);
        ar_hs = s_axi_arvalid & s_axi_arready;
        done  = s_axi_rvalid;
        d     = s_axi_rdata;
        r     = s_axi_rresp;
        @(posedge ref_clk);
        if (ar_hs)
          s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      check("rdata", d, exp);
      check("rresp", {30'h0, r}, {30'h0, er});
      @(posedge ref_clk);
    end
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    begin
      rd_chk(`SVOF_ADDR_CTRL, 32'h3, `SVOF_RESP_OKAY);
      rd_chk(`SVOF_ADDR_COLS, 32'h2f0, `SVOF_RESP_OKAY);
      rd_chk(`SVOF_ADDR_ROWS, 32'h1e0, `SVOF_RESP_OKAY);
      rd_chk(`SVOF_ADDR_HBLK, 32'h5e, `SVOF_RESP_OKAY);
      rd_chk(`SVOF_ADDR_VBLK, 32'h2d, `SVOF_RESP_OKAY);
      rd_chk(8'h18, 32'h0, `SVOF_RESP_ERR);
      axi_wr(`SVOF_ADDR_STAT, 32'h1f, `SVOF_RESP_ERR);
      $display("test_regs done");
    end
  endtask : test_regs

  // Serial pins stay idle while video keeps running
  task automatic test_idle;
    int rises;
    logic lv_prev;
    begin
      rises = 0;
      lv_prev = 1'b1;
      repeat (300)
      begin
        @(negedge ref_clk);
        check("idle pins", {ser_pos, ser_neg, pixel_rate_clock}, 3'h3);
        if (line_valid && !lv_prev)
          rises++;
        lv_prev = line_valid;
      end
      check("video alive", rises > 0, 1);
      @(posedge ref_clk);
      #10;
      check("pclk low", pixel_rate_clock, 1'b0);
      $display("test_idle done");
    end
  endtask : test_idle

  task automatic test_frame;
    int n;
    logic [9:0] exp_pix;
    begin
      axi_wr(`SVOF_ADDR_CTRL, 32'h7, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_COLS, 32'h8, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_ROWS, 32'h2, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_HBLK, 32'h4, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_VBLK, 32'h5, `SVOF_RESP_OKAY);
      @(negedge ref_clk);
      check("held", {frame_valid, line_valid, pix_data}, 12'h0);
      rd_chk(`SVOF_ADDR_STAT, 32'h20, `SVOF_RESP_OKAY);
      pix_step <= 1'b1;
      axi_wr(`SVOF_ADDR_CTRL, 32'h3, `SVOF_RESP_OKAY);
      @(negedge ref_clk);
      while (!line_valid)
        @(negedge ref_clk);
      check("lead", fv_age, `SVOF_FV_LEAD);
      for (int r = 0; r < 2; r++)
      begin
        n = 0;
        while (line_valid)
        begin
          exp_pix = pixel_in - 10'h001;
          check("pixel", {frame_valid, pix_data}, {1'b1, exp_pix});
          n++;
          @(negedge ref_clk);
        end
        check("row width", n, 8);
        n = 0;
        while (!line_valid && frame_valid)
        begin
          check("blank data", pix_data, 10'h000);
          n++;
          @(negedge ref_clk);
        end
        check("gap or tail", n, r ? 23 : 4);
      end
      $display("test_frame done");
    end
  endtask : test_frame

  task automatic test_serial;
    logic [15:0] s0, m0;
    begin
      pix_step <= 1'b0;
      axi_wr(`SVOF_ADDR_COLS, 32'h28, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_ROWS, 32'h4, `SVOF_RESP_OKAY);
      s0 = sync_cnt;
      axi_wr(`SVOF_ADDR_CTRL, 32'h2, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_CTRL, 32'h0, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_CTRL, 32'h4, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_CTRL, 32'h0, `SVOF_RESP_OKAY);
      axi_wr(`SVOF_ADDR_CTRL, 32'h8, `SVOF_RESP_OKAY);
      repeat (200) @(posedge ref_clk);
      check("sync sent", sync_cnt != s0, 1);
      axi_wr(`SVOF_ADDR_CTRL, 32'h0, `SVOF_RESP_OKAY);
      repeat (60) @(posedge ref_clk);
      s0 = sync_cnt;
      m0 = match_cnt;
      repeat (400) @(posedge ref_clk);
      check("sync stopped", sync_cnt, s0);
      check("video word", match_cnt != m0, 1);
      check("pair polarity", pol_err, 16'h0);
      axi_wr(`SVOF_ADDR_CTRL, 32'h1, `SVOF_RESP_OKAY);
      repeat (60) @(posedge ref_clk);
      $display("test_serial done");
    end
  endtask : test_serial

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    pix_step = 1'b0;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    fv_age = 0;
    pixel_in = 10'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    test_regs;
    test_idle;
    test_frame;
    test_serial;
    test_idle;
    stop_test;
  end
endmodule : tb
`default_nettype wire
